// ### rtl/adc_conversion_control.sv
// converter control: apb registers, triggers, sleep handling, sequencer
//
// What this block does
// - converter powered and converting only while module_on is set
// - writing go/done high starts a conversion when enabled
// - completion clears go/done, sets irq flag, loads result registers
// - software clearing go/done aborts and stores the partial result
// - unresolved result bits copy the most recently resolved bit
// - reset returns every register to its reset value
// - conversion continues in sleep only on the dedicated oscillator
// - completion in sleep with interrupt enabled wakes the device
// - completion in sleep with interrupt disabled powers down, module_on kept
// - sleep on another clock aborts and powers down, module_on kept
// - rising edge of selected trigger sets go/done in hardware
// - four-bit trigger_select picks timer or logic cell source
`timescale 1ns/1ps
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger sources
  input wire logic timer_zero_wrap,
  input wire logic timer_one_wrap,
  input wire logic timer_two_period_hit,
  input wire logic logic_cell_one_output,
  input wire logic logic_cell_two_output,
  // sleep and wake
  input wire logic sleepMode,
  output logic wakeReq,
  // analog core
  input wire logic compBit,
  output logic corePowered,
  output logic conv_irq_flag
);

  typedef struct packed {
    conv_state_e state;
    logic module_on;
    logic goDone;
    logic clkDedicated;
    logic irqEnable;
    logic irqFlag;
    logic [3:0] trigger_select;
    logic trigPrev;
    logic powered;
    logic wake;
    logic aborting;
    logic [31:0] rdata;
    result_t result;
  } ctrl_s;

  ctrl_s st_q;
  ctrl_s st_d;
  sar_if sar();

  // trigger mux, used once for the current level
  function automatic logic pick_trigger(input logic [3:0] sel, input logic [4:0] src);
    logic r;
    r = 1'b0;
    unique case (sel)
      `TRIG_T0_WRAP: r = src[0];
      `TRIG_T1_WRAP: r = src[1];
      `TRIG_T2_HIT: r = src[2];
      `TRIG_LC1: r = src[3];
      `TRIG_LC2: r = src[4];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic trigLevel;
  logic trigEdge;
  logic wr;
  logic rd;
  logic [31:0] wdata;

  ////////////////////////////////////////////////////////////////////
  // bus decode; zero wait states so pready is held high
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign wdata = pwdata;
  assign trigLevel = pick_trigger(st_q.trigger_select, {logic_cell_two_output,
    logic_cell_one_output, timer_two_period_hit, timer_one_wrap, timer_zero_wrap});
  assign trigEdge = trigLevel && !st_q.trigPrev;

  ////////////////////////////////////////////////////////////////////
  // control state update
  // the order of the blocks below matters: bus writes first, then the
  // trigger, then the power rule, then the sequencing case, so that a
  // hardware event in the same cycle as a software write has the last word.
  // an abort does not leave the conversion state at once: the sequencer
  // needs one more cycle to fill the unresolved bits, and leaving early
  // would drop the partial word on the floor.
  // while that fill is pending, aborting is set and any further abort
  // cause is ignored, so the sequencer sees a single abort strobe.
  // software that sets go/done during that one cycle loses the request;
  // it must wait for go/done to read back low before starting again.
  // a trigger edge in that cycle is ignored as well, since the state
  // is still the conversion state.
  // limitation: power drops in the cycle of a sleep abort, one cycle
  // before the partial word lands; the word is already held in the
  // sequencer flops, so nothing analog is needed to finish it.
  always_comb
  begin
    st_d = st_q;
    st_d.trigPrev = trigLevel;
    st_d.wake = 1'b0;
    sar.start = 1'b0;
    sar.abort = 1'b0;
    // register writes
    if (wr)
    begin
      unique case (paddr)
        `OFS_CONTROL_0:
        begin
          st_d.module_on = wdata[`BIT_MODULE_ON];
          st_d.clkDedicated = wdata[`BIT_CLK_DEDICATED];
          if (wdata[`BIT_GO_DONE] && st_q.module_on)
          begin
            st_d.goDone = 1'b1;
          end
          else if (!wdata[`BIT_GO_DONE])
          begin
            st_d.goDone = 1'b0;
          end
        end
        `OFS_CONTROL_2: st_d.trigger_select = wdata[`TRIG_MSB:`TRIG_LSB];
        `OFS_STATUS:
        begin
          st_d.irqEnable = wdata[`BIT_IRQ_ENABLE];
          // write one clears, done event below wins
          if (wdata[`BIT_IRQ_FLAG])
          begin
            st_d.irqFlag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (trigEdge && st_q.module_on && st_q.state != ST_CONV && !st_q.goDone)
    begin
      st_d.goDone = 1'b1;
    end
    if (!st_d.module_on)
    begin
      st_d.goDone = 1'b0;
      st_d.powered = 1'b0;
    end
    unique case (st_q.state)
      ST_OFF:
      begin
        st_d.powered = 1'b0;
        if (st_q.module_on && !sleepMode)
        begin
          st_d.powered = 1'b1;
          st_d.state = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (!st_q.module_on)
        begin
          st_d.state = ST_OFF;
        end
        // sleep on other clock powers down
        else if (sleepMode && !st_q.clkDedicated)
        begin
          st_d.state = ST_OFF;
          st_d.powered = 1'b0;
          st_d.goDone = 1'b0;
        end
        else if (st_q.goDone)
        begin
          sar.start = 1'b1;
          st_d.state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (sar.done)
        begin
          st_d.result = sar.value;
          st_d.goDone = 1'b0;
          st_d.aborting = 1'b0;
          st_d.state = ST_IDLE;
          if (st_q.aborting)
          begin
            // an aborted run raises no flag; power follows the abort cause
            if (!st_q.module_on || (sleepMode && !st_q.clkDedicated))
            begin
              st_d.state = ST_OFF;
              st_d.powered = 1'b0;
            end
          end
          else
          begin
            st_d.irqFlag = 1'b1;
            if (sleepMode)
            begin
              if (st_q.irqEnable)
              begin
                st_d.wake = 1'b1;
              end
              else
              begin
                st_d.powered = 1'b0;
                st_d.state = ST_OFF;
              end
            end
          end
        end
        else if (!st_q.aborting
          && (!st_q.module_on || !st_q.goDone || (sleepMode && !st_q.clkDedicated)))
        begin
          // stay here until the sequencer hands back the partial word
          sar.abort = 1'b1;
          st_d.goDone = 1'b0;
          st_d.aborting = 1'b1;
          if (sleepMode && !st_q.clkDedicated)
          begin
            st_d.powered = 1'b0;
          end
        end
      end
      default: st_d.state = ST_OFF;
    endcase
    // registered read data, captured in setup phase
    if (rd)
    begin
      unique case (paddr)
        `OFS_CONTROL_0: st_d.rdata = {29'h0, st_q.clkDedicated, st_q.goDone, st_q.module_on};
        `OFS_CONTROL_2: st_d.rdata = {28'h0, st_q.trigger_select};
        `OFS_RESULT_HIGH: st_d.rdata = {24'h0, 6'h0, st_q.result[`RES_BITS-1:8]};
        `OFS_RESULT_LOW: st_d.rdata = {24'h0, st_q.result[7:0]};
        `OFS_STATUS: st_d.rdata = {29'h0, st_q.powered, st_q.irqEnable, st_q.irqFlag};
        default: st_d.rdata = 32'h0;
      endcase
    end
  end

  // reset clears all registers and stops conversion
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer; a sample clock that stops in sleep is modelled by the abort above
  sar_engine u_engine
  (
    .clk(clk),
    .rst(rst),
    .sar(sar.engine)
  );
  assign sar.compBit = compBit;

  // outputs
  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wakeReq = st_q.wake;
  assign corePowered = st_q.powered;
  assign conv_irq_flag = st_q.irqFlag;

endmodule

// ### rtl/adc_ctrl_params.svh
// constants for the converter control block: offsets, fields, reset values, codes
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// register byte offsets on the apb bus
`define OFS_CONTROL_0 12'h000
`define OFS_CONTROL_2 12'h004
`define OFS_RESULT_HIGH 12'h008
`define OFS_RESULT_LOW 12'h00c
`define OFS_STATUS 12'h010

// converter_control_0 fields
`define BIT_MODULE_ON 0
`define BIT_GO_DONE 1
`define BIT_CLK_DEDICATED 2

// converter_control_2 fields
`define TRIG_LSB 0
`define TRIG_MSB 3

// status fields
`define BIT_IRQ_FLAG 0
`define BIT_IRQ_ENABLE 1
`define BIT_POWERED 2

// trigger select codes
`define TRIG_NONE 4'h0
`define TRIG_T0_WRAP 4'h1
`define TRIG_T1_WRAP 4'h2
`define TRIG_T2_HIT 4'h3
`define TRIG_LC1 4'h4
`define TRIG_LC2 4'h5

// result width and cycles per resolved bit
`define RES_BITS 10
`define CYC_PER_BIT 4'h4
`define RESET_CONTROL 8'h00

`endif

// ### rtl/adc_ctrl_pkg.sv
// types shared by the converter control block
package adc_ctrl_pkg;
  `include "adc_ctrl_params.svh"

  typedef enum logic [1:0]
  {
    ST_OFF = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;

  typedef logic [`RES_BITS-1:0] result_t;
endpackage

// ### rtl/sar_engine.sv
// successive approximation bit sequencer with partial-result fill
`timescale 1ns/1ps
module sar_engine
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sequencer link
  sar_if.engine sar
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [3:0] bitIdx;
    logic [3:0] cyc;
    logic lastBit;
    result_t value;
  } eng_s;

  eng_s st_q;
  eng_s st_d;

  ////////////////////////////////////////////////////////////////////
  // one bit resolved every few cycles, msb first
  always_comb
  begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (sar.start && !st_q.busy)
    begin
      st_d.busy = 1'b1;
      st_d.bitIdx = 4'(`RES_BITS - 1);
      st_d.cyc = 4'h0;
      st_d.value = '0;
    end
    else if (st_q.busy && sar.abort)
    begin
      for (int i = 0; i < `RES_BITS; i++)
      begin
        if (i <= int'(st_q.bitIdx))
        begin
          st_d.value[i] = st_q.lastBit;
        end
      end
      st_d.busy = 1'b0;
      st_d.done = 1'b1;
    end
    else if (st_q.busy)
    begin
      st_d.cyc = st_q.cyc + 4'h1;
      if (st_q.cyc == `CYC_PER_BIT - 4'h1)
      begin
        st_d.cyc = 4'h0;
        st_d.value[st_q.bitIdx] = sar.compBit;
        st_d.lastBit = sar.compBit;
        if (st_q.bitIdx == 4'h0)
        begin
          st_d.busy = 1'b0;
          st_d.done = 1'b1;
        end
        else
        begin
          st_d.bitIdx = st_q.bitIdx - 4'h1;
        end
      end
    end
  end

  // state register; lastBit resets low but start keeps it, so an instant abort copies the previous run's last bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sar.busy = st_q.busy;
  assign sar.done = st_q.done;
  assign sar.value = st_q.value;

endmodule

// ### rtl/sar_if.sv
// link between the control block and the successive approximation engine
`timescale 1ns/1ps
interface sar_if;
  logic start;
  logic abort;
  logic compBit;
  logic busy;
  logic done;
  adc_ctrl_pkg::result_t value;
  modport ctrl (output start, output abort, input busy, input done, input value);
  modport engine (input start, input abort, input compBit, output busy, output done,
    output value);
endinterface

// ### testbench/adc_ctrl_properties.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module adc_ctrl_checker
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb write side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // sleep and converter
  input wire logic sleepMode,
  input wire logic wakeReq,
  input wire logic corePowered,
  input wire logic conv_irq_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic monOn_q, dedClk_q, irqEn_q, wrCtl, wrSts;
  ////////////////////////////////////////////////////////////
  // software bits are only visible on the bus, so shadow them
  assign wrCtl = psel && penable && pwrite && paddr == `OFS_CONTROL_0;
  assign wrSts = psel && penable && pwrite && paddr == `OFS_STATUS;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      {monOn_q, dedClk_q, irqEn_q} <= 3'h0;
    else
    begin
      if (wrCtl)
        {dedClk_q, monOn_q} <= {pwdata[2], pwdata[0]};
      if (wrSts)
        irqEn_q <= pwdata[1];
    end
  end
  ////////////////////////////////////////////////////////////
  // one cycle of slack lets the power register follow the bit
  a_power_needs_on: assert property (!monOn_q ##1 !monOn_q |-> !corePowered)
    else $error("core powered while off");
  a_reset_quiet: assert property ($fell(rst) |-> !(corePowered || conv_irq_flag || wakeReq))
    else $error("outputs set after reset");
  a_flag_sticky: assert property (conv_irq_flag && !(wrSts && pwdata[0]) |=> conv_irq_flag)
    else $error("flag lost");
  a_wake_pulse: assert property (wakeReq |=> !wakeReq)
    else $error("wake longer than a cycle");
  a_wake_cause: assert property (wakeReq |-> conv_irq_flag && irqEn_q)
    else $error("wake without enabled completion");
  a_wake_done: assert property
    ($rose(conv_irq_flag) && sleepMode && irqEn_q |-> ##[0:1] wakeReq)
    else $error("no wake on completion");
  a_sleep_abort: assert property (sleepMode && !dedClk_q |-> ##[0:2] !corePowered)
    else $error("core on in sleep");
  a_sleep_off: assert property
    ($rose(conv_irq_flag) && sleepMode && !irqEn_q |-> ##[0:2] !corePowered)
    else $error("core on after sleep completion");
  c_wake: cover property (wakeReq);
  c_abort: cover property (sleepMode && monOn_q && !dedClk_q && !corePowered);
  c_done: cover property ($rose(conv_irq_flag) && sleepMode);
endmodule
bind adc_conversion_control adc_ctrl_checker u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sleepMode(sleepMode),
  .wakeReq(wakeReq), .corePowered(corePowered), .conv_irq_flag(conv_irq_flag));

// ### testbench/comp_model.sv
// comparator of the analog core
`timescale 1ns/1ps
module comp_model
(
  // clock
  input wire logic clk,
  // core side
  input wire logic powered,
  input wire logic level,
  output logic compBit
);
  logic flip_q = 1'b0;
  // an unpowered core decides nothing, so the line wanders
  always_ff @(posedge clk)
    flip_q <= ~flip_q;
  assign compBit = powered ? level : flip_q;
endmodule

// ### testbench/tb_top.sv
// bench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module tb_top
  import adc_ctrl_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleepMode = 1'b0, lvl = 1'b1, got;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [4:0] srcs = 5'h00;
  logic pready, pslverr, wakeReq, corePowered, conv_irq_flag, compBit;
  int errorCnt = 0, cmpCount = 0, cyc = 0;
  // trigger code, source index, conversion expected
  logic [7:0] rows [9] = '{8'h11, 8'h23, 8'h35, 8'h47, 8'h59, 8'h00, 8'h60, 8'hf8, 8'h12};
  logic [11:0] regs [6] = '{`OFS_CONTROL_0, `OFS_CONTROL_2, `OFS_RESULT_HIGH,
    `OFS_RESULT_LOW, `OFS_STATUS, 12'h020};
  always #12.5 clk = ~clk;
  adc_conversion_control i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_zero_wrap(srcs[0]), .timer_one_wrap(srcs[1]),
    .timer_two_period_hit(srcs[2]), .logic_cell_one_output(srcs[3]),
    .logic_cell_two_output(srcs[4]), .sleepMode(sleepMode), .wakeReq(wakeReq),
    .compBit(compBit), .corePowered(corePowered), .conv_irq_flag(conv_irq_flag));
  comp_model i_comp (.clk(clk), .powered(corePowered), .level(lvl), .compBit(compBit));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdv, e);
    check({31'h0, pslverr}, 32'h0);
  endtask
  // bounded wait for completion or wake
  task automatic ev(input logic wake, input int n, input logic e);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++)
    begin
      @(posedge clk);
      got = (wake ? wakeReq : conv_irq_flag) === 1'b1;
    end
    check({31'h0, got}, {31'h0, e});
  endtask
  task automatic pulse(input int s);
    srcs[s] <= 1'b1;
    repeat (2) @(posedge clk);
    srcs <= 5'h00;
    @(posedge clk);
  endtask
  task automatic closeOut();
    $display("errors %0d comparisons %0d", errorCnt, cmpCount);
    if (errorCnt == 0 && cmpCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // whole run is near 1100 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errorCnt++;
      closeOut();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (regs[k])
      rc(regs[k], 32'h0);
    wr(`OFS_CONTROL_0, 32'h1);
    // trigger edges spaced past a conversion
    foreach (rows[k])
    begin
      wr(`OFS_STATUS, 32'h1);
      wr(`OFS_CONTROL_2, {28'h0, rows[k][7:4]});
      pulse(rows[k][3:1]);
      ev(1'b0, 80, rows[k][0]);
      if (got)
        rc(`OFS_RESULT_LOW, 32'hff);
    end
    lvl <= 1'b0;
    wr(`OFS_STATUS, 32'h1);
    wr(`OFS_CONTROL_0, 32'h3);
    repeat (25) @(posedge clk);
    pulse(0);
    ev(1'b0, 25, 1'b1);
    rc(`OFS_CONTROL_0, 32'h1);
    rc(`OFS_RESULT_LOW, 32'h0);
    lvl <= 1'b1;
    wr(`OFS_STATUS, 32'h1);
    wr(`OFS_CONTROL_0, 32'h3);
    repeat (15) @(posedge clk);
    wr(`OFS_CONTROL_0, 32'h1);
    ev(1'b0, 60, 1'b0);
    rc(`OFS_RESULT_HIGH, 32'h3);
    rc(`OFS_RESULT_LOW, 32'hff);
    wr(`OFS_CONTROL_0, 32'h0);
    wr(`OFS_CONTROL_0, 32'h3);
    rc(`OFS_CONTROL_0, 32'h1);
    ev(1'b0, 60, 1'b0);
    wr(`OFS_CONTROL_0, 32'h3);
    repeat (8) @(posedge clk);
    sleepMode <= 1'b1;
    ev(1'b0, 60, 1'b0);
    apb(1'b0, `OFS_CONTROL_0, 32'h0);
    check({31'h0, rdv[0]}, 32'h1);
    sleepMode <= 1'b0;
    wr(`OFS_STATUS, 32'h3);
    wr(`OFS_CONTROL_0, 32'h7);
    repeat (4) @(posedge clk);
    sleepMode <= 1'b1;
    ev(1'b1, 80, 1'b1);
    sleepMode <= 1'b0;
    wr(`OFS_STATUS, 32'h1);
    wr(`OFS_CONTROL_0, 32'h7);
    repeat (4) @(posedge clk);
    sleepMode <= 1'b1;
    ev(1'b0, 80, 1'b1);
    repeat (3) @(posedge clk);
    check({31'h0, corePowered}, 32'h0);
    apb(1'b0, `OFS_CONTROL_0, 32'h0);
    check({31'h0, rdv[0]}, 32'h1);
    sleepMode <= 1'b0;
    wr(`OFS_CONTROL_0, 32'h3);
    repeat (10) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (regs[k])
      rc(regs[k], 32'h0);
    closeOut();
  end
endmodule
